// File: src/stp_defs.vh
// Constants for the target-side bus port: opcodes, field positions,
// status and message codes, reset values and timing counts.
// Assumes a 200 MHz core clock; included by the port module only.
`ifndef STP_DEFS_VH
`define STP_DEFS_VH

// ----------------------------------------------------------------
// Opcodes and command byte positions
// ----------------------------------------------------------------
`define STP_OP_MSEL      8'h15
`define STP_OP_FMT       8'h04
`define STP_CMD_LAST     3'h5
`define STP_CB_LUN       3'h1
`define STP_CB_CNT       3'h4
`define STP_CB_ILV_HI    3'h3
`define STP_CB_ILV_LO    3'h4
`define STP_LUN_MSB      7
`define STP_LUN_LSB      5
`define STP_FMT_FLAGS    4:0

// ----------------------------------------------------------------
// Parameter list layout
// ----------------------------------------------------------------
`define STP_IDX_PAGE     8'h04
`define STP_IDX_PLEN     8'h05
`define STP_IDX_ALT_HI   8'h08
`define STP_IDX_ALT_LO   8'h09
`define STP_PAGE_FMT     8'h03
`define STP_PAGE_LEN     8'h16

// ----------------------------------------------------------------
// Status, messages, reset values
// ----------------------------------------------------------------
`define STP_ST_GOOD      8'h00
`define STP_ST_CHECK     8'h02
`define STP_MSG_DONE     8'h00
`define STP_MSG_IDENT    8'h80
`define STP_SPARE_RST    16'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define STP_CLK_NS       5
`define STP_BUS_FREE_NS  800
`define STP_ARB_NS       2400
`define STP_BUS_FREE_CYC ((`STP_BUS_FREE_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)
`define STP_ARB_CYC      ((`STP_ARB_NS + `STP_CLK_NS - 1) / `STP_CLK_NS)

`endif

// File: src/stp_port.v
// Target-side bus port with command front end for two drives.
// Assumes bus pins are already synchronous to clk and that the drive
// side answers format starts with fmt_done for the same unit.
`timescale 1ns/1ps
`default_nettype none
`include "stp_defs.vh"

module stp_port (
  input  wire        clk,
  input  wire        reset_n,
  input  wire [2:0]  own_id,
  input  wire        parity_chk_en,
  input  wire [7:0]  sec_per_trk,
  input  wire [15:0] max_cyl,
  input  wire        bsy_in,
  output wire        bsy_out,
  output reg         bsy_oe,
  input  wire        sel_in,
  output wire        sel_out,
  output reg         sel_oe,
  input  wire        rst_in,
  input  wire        atn_in,
  input  wire        ack_in,
  output reg         req_out,
  output wire        cd_out,
  output wire        io_out,
  output wire        msg_out,
  input  wire [7:0]  db_in,
  input  wire        dbp_in,
  output reg  [7:0]  db_out,
  output wire        dbp_out,
  output reg         db_oe,
  output wire        par_valid,
  input  wire        par_ready,
  output wire [7:0]  par_data,
  output reg         fmt_start,
  output reg         fmt_lun,
  output reg  [7:0]  fmt_interleave,
  output reg  [15:0] fmt_spares,
  output reg         fmt_use_lists,
  output reg         fmt_map_mfr,
  input  wire        fmt_done,
  input  wire        fmt_done_lun,
  output reg  [1:0]  lun_busy,
  input  wire        rsg_req,
  input  wire [15:0] rsg_cyl,
  input  wire        rsg_same_free,
  output reg         rsg_valid,
  output reg  [15:0] rsg_spare_cyl,
  input  wire        resel_req,
  input  wire [2:0]  resel_init_id,
  input  wire        resel_lun,
  input  wire        resel_check,
  output reg         resel_done
);

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam ST_IDLE = 4'h0;
  localparam ST_SELD = 4'h1;
  localparam ST_MOUT = 4'h2;
  localparam ST_CMD  = 4'h3;
  localparam ST_DOUT = 4'h4;
  localparam ST_STAT = 4'h5;
  localparam ST_MIN  = 4'h6;
  localparam ST_FWT  = 4'h7;
  localparam ST_ARBW = 4'h8;
  localparam ST_ARB  = 4'h9;
  localparam ST_RSEL = 4'hA;
  localparam ST_RWT  = 4'hB;
  localparam ST_RID  = 4'hC;

  localparam HS_IDLE = 2'h0;
  localparam HS_REQ  = 2'h1;
  localparam HS_REL  = 2'h2;
  localparam HS_LOAD = 2'h3;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Phase lines as {msg, cd, io}
  function [2:0] phase_of;
    input [3:0] s;
    begin
      case (s)
        ST_MOUT: phase_of = 3'h6;
        ST_CMD:  phase_of = 3'h2;
        ST_STAT: phase_of = 3'h3;
        ST_MIN:  phase_of = 3'h7;
        ST_RID:  phase_of = 3'h7;
        ST_RSEL: phase_of = 3'h1;
        ST_RWT:  phase_of = 3'h1;
        default: phase_of = 3'h0;
      endcase
    end
  endfunction

  function odd_par;
    input [7:0] b;
    begin
      odd_par = ~^b;
    end
  endfunction

  function [7:0] id_bit;
    input [2:0] id;
    begin
      id_bit = 8'h01 << id;
    end
  endfunction

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  reg  [1:0] rsync_ff;
  wire       rst_n_i = rsync_ff[1];

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rsync_ff <= 2'h0;
    else
      rsync_ff <= {rsync_ff[0], 1'b1};
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [3:0]  state_ff;
  reg  [3:0]  ret_ff;
  reg  [1:0]  hs_ff;
  reg  [2:0]  phase_ff;
  reg  [7:0]  rx_ff;
  reg  [7:0]  cmd_ff [0:5];
  reg  [2:0]  cidx_ff;
  reg  [7:0]  pidx_ff;
  reg  [7:0]  status_ff;
  reg  [7:0]  alt_hi_ff;
  reg  [15:0] alt_new_ff;
  reg         perr_ff;
  reg         resel_ff;
  reg         cur_lun_ff;
  reg  [8:0]  tmr_ff;
  reg  [15:0] spares_ff [0:1];
  reg  [7:0]  buf_ff [0:1];
  reg         wr_ff;
  reg         rd_ff;
  reg  [1:0]  cnt_ff;

  wire [7:0] op      = cmd_ff[0];
  wire       lun_bad = |cmd_ff[`STP_CB_LUN][`STP_LUN_MSB:`STP_LUN_LSB+1];
  wire       lun_sel = cmd_ff[`STP_CB_LUN][`STP_LUN_LSB];
  wire       buf_room = (cnt_ff != 2'h2);
  wire       pop      = par_valid && par_ready;
  wire       in_xfer  = (state_ff == ST_MOUT) || (state_ff == ST_CMD) ||
                        (state_ff == ST_DOUT) || (state_ff == ST_STAT) ||
                        (state_ff == ST_MIN)  || (state_ff == ST_RID);
  wire       room_ok  = (state_ff != ST_DOUT) || buf_room;
  wire       byte_done = (hs_ff == HS_REL) && !ack_in;
  wire [7:0] above    = db_in & (8'hFE << own_id);
  reg  [7:0] tx_byte;
  reg        cmd_bad;

  always @*
  begin
    case (state_ff)
      ST_STAT: tx_byte = status_ff;
      ST_RID:  tx_byte = `STP_MSG_IDENT | {7'h00, cur_lun_ff};
      default: tx_byte = `STP_MSG_DONE;
    endcase
  end

  // Command screening
  always @*
  begin
    cmd_bad = lun_bad;
    if ((op != `STP_OP_MSEL) && (op != `STP_OP_FMT))
      cmd_bad = 1'b1;
    if ((op == `STP_OP_FMT) && (cmd_ff[`STP_CB_LUN][`STP_FMT_FLAGS] != 5'h00))
      cmd_bad = 1'b1;
    // interleave range
    // Stored low byte, since rx_ff holds the final byte at this point
    if ((op == `STP_OP_FMT) && ((cmd_ff[`STP_CB_ILV_HI] != 8'h00) ||
        (cmd_ff[`STP_CB_ILV_LO] == 8'h00) || (cmd_ff[`STP_CB_ILV_LO] > sec_per_trk)))
      cmd_bad = 1'b1;
    if ((op == `STP_OP_FMT) && lun_busy[lun_sel])
      cmd_bad = 1'b1;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // open-drain, level comes from oe
  assign bsy_out = 1'b1;
  assign sel_out = 1'b1;
  assign msg_out = phase_ff[2];
  assign cd_out  = phase_ff[1];
  assign io_out  = phase_ff[0];
  assign dbp_out = odd_par(db_out);

  // ----------------------------------------------------------------
  // Two-entry parameter buffer
  // ----------------------------------------------------------------
  assign par_valid = (cnt_ff != 2'h0);
  assign par_data  = buf_ff[rd_ff];

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff   <= ST_IDLE;
      ret_ff     <= ST_CMD;
      hs_ff      <= HS_IDLE;
      phase_ff   <= 3'h0;
      rx_ff      <= 8'h00;
      cidx_ff    <= 3'h0;
      pidx_ff    <= 8'h00;
      status_ff  <= `STP_ST_GOOD;
      alt_hi_ff  <= 8'h00;
      alt_new_ff <= `STP_SPARE_RST;
      perr_ff    <= 1'b0;
      resel_ff   <= 1'b0;
      cur_lun_ff <= 1'b0;
      tmr_ff     <= 9'h000;
      spares_ff[0] <= `STP_SPARE_RST;
      spares_ff[1] <= `STP_SPARE_RST;
      buf_ff[0]  <= 8'h00;
      buf_ff[1]  <= 8'h00;
      wr_ff      <= 1'b0;
      rd_ff      <= 1'b0;
      cnt_ff     <= 2'h0;
      bsy_oe     <= 1'b0;
      sel_oe     <= 1'b0;
      req_out    <= 1'b0;
      db_out     <= 8'h00;
      db_oe      <= 1'b0;
      fmt_start  <= 1'b0;
      fmt_lun    <= 1'b0;
      fmt_interleave <= 8'h00;
      fmt_spares <= `STP_SPARE_RST;
      fmt_use_lists <= 1'b0;
      fmt_map_mfr <= 1'b0;
      lun_busy   <= 2'h0;
      rsg_valid  <= 1'b0;
      rsg_spare_cyl <= 16'h0000;
      resel_done <= 1'b0;
      cmd_ff[0] <= 8'h00; cmd_ff[1] <= 8'h00; cmd_ff[2] <= 8'h00;
      cmd_ff[3] <= 8'h00; cmd_ff[4] <= 8'h00; cmd_ff[5] <= 8'h00;
    end
    else
    begin
      fmt_start  <= 1'b0;
      resel_done <= 1'b0;
      rsg_valid  <= 1'b0;
      phase_ff   <= phase_of(state_ff);
      if (in_xfer)
        db_oe <= phase_ff[0];
      // spare in same cylinder or max minus one
      if (rsg_req)
      begin
        rsg_valid     <= 1'b1;
        rsg_spare_cyl <= rsg_same_free ? rsg_cyl : (max_cyl - 16'h0001);
      end
      if (fmt_done)
        lun_busy[fmt_done_lun] <= 1'b0;
      // Buffer bookkeeping; push happens below on data-out bytes
      if (pop)
        rd_ff <= ~rd_ff;
      if (pop && !(byte_done && (state_ff == ST_DOUT)))
        cnt_ff <= cnt_ff - 2'h1;

      if (in_xfer)
      begin
        case (hs_ff)
          HS_IDLE:
            if (phase_ff == phase_of(state_ff) && room_ok)
            begin
              db_out <= tx_byte;
              hs_ff  <= HS_LOAD;
            end
          HS_LOAD:
          begin
            req_out <= 1'b1;
            hs_ff   <= HS_REQ;
          end
          HS_REQ:
            if (ack_in)
            begin
              rx_ff   <= db_in;
              req_out <= 1'b0;
              hs_ff   <= HS_REL;
              if (parity_chk_en && !phase_ff[0] && (dbp_in != odd_par(db_in)))
                perr_ff <= 1'b1;
            end
          default:
            if (!ack_in)
              hs_ff <= HS_IDLE;
        endcase
      end

      case (state_ff)
        ST_IDLE:
        begin
          bsy_oe   <= 1'b0;
          sel_oe   <= 1'b0;
          db_oe    <= 1'b0;
          resel_ff <= 1'b0;
          perr_ff  <= 1'b0;
          cidx_ff  <= 3'h0;
          tmr_ff   <= 9'h000;
          if (sel_in && !bsy_in && (db_in & id_bit(own_id)) != 8'h00)
          begin
            bsy_oe   <= 1'b1;
            state_ff <= ST_SELD;
          end
          else if (resel_req)
          begin
            cur_lun_ff <= resel_lun;
            status_ff  <= resel_check ? `STP_ST_CHECK : `STP_ST_GOOD;
            state_ff   <= ST_ARBW;
          end
        end
        ST_SELD:
          if (!sel_in)
          begin
            ret_ff   <= ST_CMD;
            state_ff <= atn_in ? ST_MOUT : ST_CMD;
          end
        ST_MOUT:
          if (byte_done)
            state_ff <= ret_ff;
        ST_CMD:
          if (byte_done)
          begin
            cmd_ff[cidx_ff] <= rx_ff;
            cidx_ff <= cidx_ff + 3'h1;
            pidx_ff <= 8'h00;
            cur_lun_ff <= lun_sel;
            if (cidx_ff == `STP_CMD_LAST)
            begin
              if (cmd_bad || perr_ff)
              begin
                status_ff <= `STP_ST_CHECK;
                state_ff  <= ST_STAT;
              end
              else if (op == `STP_OP_MSEL && cmd_ff[`STP_CB_CNT] != 8'h00)
              begin
                // Clear any check left by an earlier command
                status_ff <= `STP_ST_GOOD;
                state_ff  <= ST_DOUT;
              end
              else if (op == `STP_OP_MSEL)
              begin
                status_ff <= `STP_ST_GOOD;
                state_ff  <= ST_STAT;
              end
              else
              begin
                fmt_start      <= 1'b1;
                fmt_lun        <= lun_sel;
                fmt_interleave <= cmd_ff[`STP_CB_ILV_LO];
                fmt_spares     <= spares_ff[lun_sel];
                fmt_use_lists  <= 1'b1;
                fmt_map_mfr    <= 1'b1;
                lun_busy[lun_sel] <= 1'b1;
                status_ff      <= `STP_ST_GOOD;
                state_ff       <= ST_FWT;
              end
            end
          end
        ST_DOUT:
          if (byte_done)
          begin
            buf_ff[wr_ff] <= rx_ff;
            wr_ff   <= ~wr_ff;
            if (!pop)
              cnt_ff <= cnt_ff + 2'h1;
            pidx_ff <= pidx_ff + 8'h01;
            if ((pidx_ff == `STP_IDX_PAGE && rx_ff != `STP_PAGE_FMT) ||
                (pidx_ff == `STP_IDX_PLEN && rx_ff != `STP_PAGE_LEN))
              status_ff <= `STP_ST_CHECK;
            if (pidx_ff == `STP_IDX_ALT_HI)
              alt_hi_ff <= rx_ff;
            if (pidx_ff == `STP_IDX_ALT_LO)
              alt_new_ff <= {alt_hi_ff, rx_ff};
            if (pidx_ff + 8'h01 == cmd_ff[`STP_CB_CNT])
              state_ff <= ST_STAT;
          end
        ST_FWT:
          if (fmt_done && fmt_done_lun == cur_lun_ff)
            state_ff <= ST_STAT;
        ST_STAT:
        begin
          if (perr_ff)
            status_ff <= `STP_ST_CHECK;
          if (hs_ff == HS_IDLE && atn_in)
          begin
            ret_ff   <= ST_STAT;
            state_ff <= ST_MOUT;
          end
          else if (byte_done)
          begin
            // Spares commit only with good status, so a bad page is harmless
            if (op == `STP_OP_MSEL && status_ff == `STP_ST_GOOD && !resel_ff)
              spares_ff[cur_lun_ff] <= alt_new_ff;
            state_ff <= ST_MIN;
          end
        end
        ST_MIN:
          if (byte_done)
          begin
            resel_done <= resel_ff;
            state_ff   <= ST_IDLE;
          end
        ST_ARBW:
        begin
          if (bsy_in || sel_in)
            tmr_ff <= 9'h000;
          else if (tmr_ff == `STP_BUS_FREE_CYC)
          begin
            bsy_oe   <= 1'b1;
            db_out   <= id_bit(own_id);
            db_oe    <= 1'b1;
            tmr_ff   <= 9'h000;
            state_ff <= ST_ARB;
          end
          else
            tmr_ff <= tmr_ff + 9'h001;
        end
        ST_ARB:
          if (tmr_ff == `STP_ARB_CYC)
          begin
            tmr_ff <= 9'h000;
            // higher address wins, we back off
            if (above != 8'h00 || sel_in)
            begin
              bsy_oe   <= 1'b0;
              db_oe    <= 1'b0;
              state_ff <= ST_ARBW;
            end
            else
            begin
              sel_oe   <= 1'b1;
              state_ff <= ST_RSEL;
            end
          end
          else
            tmr_ff <= tmr_ff + 9'h001;
        // reselect to finish a disconnected job
        ST_RSEL:
        begin
          db_out <= id_bit(own_id) | id_bit(resel_init_id);
          if (phase_ff[0])
          begin
            bsy_oe   <= 1'b0;
            state_ff <= ST_RWT;
          end
        end
        ST_RWT:
          if (bsy_in)
          begin
            bsy_oe   <= 1'b1;
            sel_oe   <= 1'b0;
            db_oe    <= 1'b0;
            resel_ff <= 1'b1;
            state_ff <= ST_RID;
          end
        ST_RID:
          if (byte_done)
            state_ff <= ST_STAT;
        default:
          state_ff <= ST_IDLE;
      endcase

      // Bus reset from another device drops the connection: state, handshake, REQ, BSY, SEL and data drive
      if (rst_in)
      begin
        state_ff <= ST_IDLE;
        hs_ff    <= HS_IDLE;
        req_out  <= 1'b0;
        bsy_oe   <= 1'b0;
        sel_oe   <= 1'b0;
        db_oe    <= 1'b0;
      end
    end
  end

endmodule // stp_port

`default_nettype wire

// File: tb/stp_port_properties.sv
// Checker for the bus port: handshake, parity, format and spare outputs.
// Bound to stp_port; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module stp_port_properties (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        rst_in,
  input wire logic        ack_in,
  input wire logic        req_out,
  input wire logic        bsy_oe,
  input wire logic [7:0]  db_out,
  input wire logic        dbp_out,
  input wire logic        rsg_req,
  input wire logic        rsg_same_free,
  input wire logic [15:0] rsg_cyl,
  input wire logic [15:0] max_cyl,
  input wire logic        rsg_valid,
  input wire logic [15:0] rsg_spare_cyl,
  input wire logic        fmt_start,
  input wire logic        fmt_lun,
  input wire logic [7:0]  fmt_interleave,
  input wire logic [7:0]  sec_per_trk,
  input wire logic        fmt_use_lists,
  input wire logic        fmt_map_mfr,
  input wire logic [1:0]  lun_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  chk_req_drops: assert property (req_out && ack_in |=> !req_out)
    else $error("REQ held after ACK");
  chk_req_waits: assert property (req_out && !ack_in && !rst_in |=> req_out)
    else $error("REQ dropped before ACK");
  chk_req_quiet: assert property (!req_out && ack_in |=> !req_out)
    else $error("REQ raised while ACK high");
  chk_odd_parity: assert property (^{db_out, dbp_out})
    else $error("data parity not odd");
  chk_spare_pick: assert property (rsg_req |=> rsg_valid && rsg_spare_cyl ==
    ($past(rsg_same_free) ? $past(rsg_cyl) : $past(max_cyl) - 16'h0001))
    else $error("wrong spare cylinder");
  chk_fmt_ilv: assert property (fmt_start |-> fmt_interleave != 8'h00 &&
    fmt_interleave <= sec_per_trk)
    else $error("interleave out of range");
  chk_fmt_lists: assert property (fmt_start |-> fmt_use_lists && fmt_map_mfr)
    else $error("format without stored lists");
  chk_unit_busy: assert property (fmt_start |=> lun_busy[$past(fmt_lun)])
    else $error("unit not marked busy");
  chk_bus_reset: assert property (rst_in |=> !req_out && !bsy_oe)
    else $error("bus held through reset");
endmodule // stp_port_properties

`default_nettype wire

// File: tb/stp_host_model.sv
// Host initiator model: selection and REQ/ACK byte moves.
// Assumes active-high bus lines, wired OR outside; released lines read 0.
`timescale 1ns/1ps
`default_nettype none

module stp_host_model (
  input  wire logic       clk,
  input  wire logic       req_out,
  input  wire logic       msg_out,
  input  wire logic       cd_out,
  input  wire logic       io_out,
  input  wire logic       bsy_oe,
  input  wire logic [7:0] db_in,
  output logic            ack_in,
  output logic            atn_in,
  output logic            sel_host,
  output logic [7:0]      db_host,
  output logic            dbp_host,
  output logic            bsy_host,
  output logic            hang
);
  logic bad_par = 1'b0;
  initial
  begin
    ack_in = 1'b0;
    atn_in = 1'b0;
    sel_host = 1'b0;
    db_host = 8'h00;
    dbp_host = 1'b1;
    hang = 1'b0;
    bsy_host = 1'b0;
  end
  // Bounded wait; a silent target marks a hang
  task wait_req(input logic lvl);
    integer k;
    @(posedge clk);
    for (k = 0; k < 4000 && req_out !== lvl; k = k + 1) @(posedge clk);
    hang = hang | (req_out !== lvl);
  endtask
  task select(input logic [7:0] ids, input logic atn);
    integer k;
    db_host <= ids;
    dbp_host <= ~^ids;
    sel_host <= 1'b1;
    atn_in <= atn;
    @(posedge clk);
    for (k = 0; k < 4000 && !bsy_oe; k = k + 1) @(posedge clk);
    hang = hang | !bsy_oe;
    sel_host <= 1'b0;
    db_host <= 8'h00;
    dbp_host <= 1'b1;
  endtask
  task xfer(input logic [7:0] cb, input logic [7:0] dat, output logic [7:0] bi,
            output logic [2:0] ph);
    logic [7:0] bo;
    wait_req(1'b1);
    ph = {msg_out, cd_out, io_out};
    bi = db_in;
    bo = (ph == 3'b010) ? cb : (ph == 3'b110) ? 8'h80 : dat;
    db_host <= io_out ? 8'h00 : bo;
    dbp_host <= io_out ? 1'b1 : (~^bo ^ bad_par);
    ack_in <= 1'b1;
    wait_req(1'b0);
    ack_in <= 1'b0;
    db_host <= 8'h00;
    dbp_host <= 1'b1;
    if (ph == 3'b110) atn_in <= 1'b0;
  endtask
  // answer reselection with busy, release once target holds busy
  task answer_resel;
    integer k;
    for (k = 0; k < 4000 && !(io_out && !bsy_oe); k = k + 1) @(posedge clk);
    bsy_host <= 1'b1;
    for (k = 0; k < 4000 && !bsy_oe; k = k + 1) @(posedge clk);
    hang = hang | !bsy_oe;
    bsy_host <= 1'b0;
  endtask
endmodule // stp_host_model

`default_nettype wire

// File: tb/stp_port_tb.sv
// Testbench for stp_port: host model, parameter consumer, format responder.
// Assumes a 200 MHz clock and non-arbitrating selection by host id 7.
`timescale 1ns/1ps
`default_nettype none

module stp_port_tb;
  logic clk = 1'b0, reset_n = 1'b0, rst_in = 1'b0, par_ready = 1'b0;
  logic parity_chk_en = 1'b1, fmt_done = 1'b0, fmt_done_lun = 1'b0;
  logic rsg_req = 1'b0, rsg_same_free = 1'b0, resel_req = 1'b0;
  logic resel_lun = 1'b0, resel_check = 1'b0, f_lun = 1'b0;
  logic [2:0]  own_id = 3'h2, resel_init_id = 3'h7;
  logic [7:0]  sec_per_trk = 8'h11, f_ilv = 8'h00;
  logic [15:0] max_cyl = 16'h0400, rsg_cyl = 16'h0000, f_sp = 16'h0000;
  logic [7:0]  pl [0:27];
  logic [7:0]  got [0:31];
  logic [7:0]  rb [0:2];
  logic [2:0]  rph;
  integer n_mismatch = 0, cmp_count = 0, ng = 0, nfmt = 0, fcnt = 0, cyc = 0, k;
  integer nresel = 0;
  wire logic bsy_out, bsy_oe, sel_out, sel_oe, req_out, cd_out, io_out, msg_out;
  wire logic dbp_out, db_oe, par_valid, fmt_start, fmt_lun, fmt_use_lists, fmt_map_mfr;
  wire logic rsg_valid, ack_in, atn_in, sel_host, dbp_host, hang, bsy_host, resel_done;
  wire logic [7:0]  db_out, par_data, fmt_interleave, db_host;
  wire logic [15:0] fmt_spares, rsg_spare_cyl;
  wire logic [1:0]  lun_busy;
  wire logic [7:0]  db_in = db_host | (db_oe ? db_out : 8'h00);
  wire logic        dbp_in = db_oe ? dbp_out : dbp_host;
  wire logic        bsy_in = (bsy_oe & bsy_out) | bsy_host;
  wire logic        sel_in = sel_host | (sel_oe & sel_out);
  localparam logic [335:0] BADS = {48'h04_40_00_00_01_00, 48'h1F_00_00_00_01_00,
    48'h04_00_00_01_01_00, 48'h04_00_00_00_00_00, 48'h04_00_00_00_12_00,
    48'h04_01_00_00_01_00, 48'h04_00_00_00_01_00};

  stp_port dut_u (.clk, .reset_n, .own_id, .parity_chk_en, .sec_per_trk, .max_cyl,
    .bsy_in, .bsy_out, .bsy_oe, .sel_in, .sel_out, .sel_oe, .rst_in, .atn_in, .ack_in,
    .req_out, .cd_out, .io_out, .msg_out, .db_in, .dbp_in, .db_out, .dbp_out, .db_oe,
    .par_valid, .par_ready, .par_data, .fmt_start, .fmt_lun, .fmt_interleave, .fmt_spares,
    .fmt_use_lists, .fmt_map_mfr, .fmt_done, .fmt_done_lun, .lun_busy, .rsg_req, .rsg_cyl,
    .rsg_same_free, .rsg_valid, .rsg_spare_cyl, .resel_req, .resel_init_id, .resel_lun,
    .resel_check, .resel_done);
  stp_host_model host_u (.clk, .req_out, .msg_out, .cd_out, .io_out, .bsy_oe, .db_in,
    .ack_in, .atn_in, .sel_host, .db_host, .dbp_host, .bsy_host, .hang);

  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // Consumer stalls in bursts so the two-entry buffer fills
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    par_ready <= cyc[5];
    if (par_valid && par_ready && ng < 32) got[ng] <= par_data;
    ng <= ng + (par_valid && par_ready);
    if (fmt_start) {f_lun, f_ilv, f_sp} <= {fmt_lun, fmt_interleave, fmt_spares};
    nfmt <= nfmt + fmt_start;
    nresel <= nresel + resel_done;
    fcnt <= fmt_start ? 20 : (fcnt > 0 ? fcnt - 1 : 0);
    fmt_done <= (fcnt == 1);
    fmt_done_lun <= f_lun;
  end

  task check(input logic [47:0] seen, input logic [47:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("BAD at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task run_cmd(input logic [47:0] cdb, input integer nd, input logic atn, input logic [7:0] est);
    integer i, nc, ndo, nmo;
    logic [7:0] bi, st, mg;
    logic [2:0] ph;
    nc = 0;
    ndo = 0;
    nmo = 0;
    st = 8'hFF;
    mg = 8'hFF;
    ph = 3'b000;
    host_u.select(8'h80 | (8'h01 << own_id), atn);
    for (i = 0; i < 64 && ph != 3'b111 && !hang; i = i + 1)
    begin
      host_u.xfer(cdb[47 - 8 * nc -: 8], pl[ndo], bi, ph);
      nc = nc + (ph == 3'b010);
      ndo = ndo + (ph == 3'b000);
      nmo = nmo + (ph == 3'b110);
      if (ph == 3'b011) st = bi;
      if (ph == 3'b111) mg = bi;
    end
    for (i = 0; i < 100 && bsy_oe; i = i + 1) @(posedge clk);
    if (hang || bsy_oe)
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
    check(nc, 6);
    check(ndo, nd);
    check(nmo, atn);
    check(st, est);
    check(mg, 8'h00);
  endtask

  initial
  begin
    for (k = 0; k < 28; k = k + 1) pl[k] = 8'h00;
    pl[4] = 8'h03;
    pl[5] = 8'h16;
    pl[9] = 8'h02;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    run_cmd(48'h15_00_00_00_1C_00, 28, 1'b1, 8'h00);
    // Consumer may still be stalled with two bytes held
    for (k = 0; k < 100 && ng < 28; k = k + 1) @(posedge clk);
    for (k = 0; k < 28; k = k + 1) check(got[k], pl[k]);
    check(ng, 28);
    run_cmd(48'h04_00_00_00_01_00, 0, 1'b0, 8'h00);
    check({f_lun, f_ilv, f_sp}, {1'b0, 8'h01, 16'h0002});
    run_cmd(48'h04_20_00_00_11_00, 0, 1'b0, 8'h00);
    check({f_lun, f_ilv}, {1'b1, 8'h11});
    for (k = 0; k < 7; k = k + 1)
    begin
      host_u.bad_par = (k == 6);
      run_cmd(BADS[335 - 48 * k -: 48], 0, 1'b0, 8'h02);
    end
    check(nfmt, 2);
    // Parity ignored while checking is off
    parity_chk_en <= 1'b0;
    run_cmd(48'h04_00_00_00_01_00, 0, 1'b0, 8'h00);
    host_u.bad_par = 1'b0;
    for (k = 0; k < 2; k = k + 1)
    begin
      rsg_cyl <= 16'h0123;
      rsg_same_free <= k[0];
      rsg_req <= 1'b1;
      @(posedge clk);
      rsg_req <= 1'b0;
      @(posedge clk);
      check({rsg_valid, rsg_spare_cyl}, {1'b1, k[0] ? 16'h0123 : 16'h03FF});
    end
    // Bus reset while REQ stands for the first command byte
    host_u.select(8'h80 | (8'h01 << own_id), 1'b0);
    for (k = 0; k < 20 && !req_out; k = k + 1) @(posedge clk);
    check(req_out, 1'b1);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk);
    check({req_out, bsy_oe}, 2'b00);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk);
    run_cmd(48'h04_20_00_00_01_00, 0, 1'b0, 8'h00);
    // Reselection: bus free, arbitration won, identify, status, message
    resel_lun <= 1'b1;
    resel_check <= 1'b1;
    resel_req <= 1'b1;
    @(posedge clk);
    resel_req <= 1'b0;
    host_u.answer_resel;
    for (k = 0; k < 3; k = k + 1)
    begin
      host_u.xfer(8'h00, 8'h00, rb[k], rph);
      check(rph, (k == 1) ? 3'b011 : 3'b111);
    end
    check({rb[0], rb[1], rb[2]}, 24'h81_02_00);
    repeat (4) @(posedge clk);
    check({hang, nresel}, 33'h000000001);
    final_report;
  end
endmodule // stp_port_tb

bind stp_port stp_port_properties chk_u (.clk, .reset_n, .rst_in, .ack_in, .req_out,
  .bsy_oe, .db_out, .dbp_out, .rsg_req, .rsg_same_free, .rsg_cyl, .max_cyl, .rsg_valid,
  .rsg_spare_cyl, .fmt_start, .fmt_lun, .fmt_interleave, .sec_per_trk, .fmt_use_lists,
  .fmt_map_mfr, .lun_busy);

`default_nettype wire
